// ==== rtcp_pkg.sv ====
// Shared constants and state types of the paged cache port.
package rtcp_pkg;
  localparam int         PAGE_W        = 5;
  localparam int         WORD_W        = 3;
  localparam logic [6:0] SLV_ADDR      = 7'h56;
  localparam logic       RW_WR         = 1'b0;
  localparam logic       RW_RD         = 1'b1;
  localparam logic [7:0] PTR_RST       = 8'h00;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;
  localparam int         FIFO_W        = 8;
  localparam int         FIFO_D        = 8;
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         SCL_PERIOD_NS = 320;
  localparam int         SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [1:0] K_ADDR        = 2'h0;
  localparam logic [1:0] K_PTR         = 2'h1;
  localparam logic [1:0] K_WD          = 2'h2;
  localparam logic [1:0] K_RD          = 2'h3;

  typedef enum logic [6:0] {
    D_IDLE = 7'h01,
    D_ADDR = 7'h02,
    D_ACK  = 7'h04,
    D_RX   = 7'h08,
    D_TX   = 7'h10,
    D_MACK = 7'h20,
    D_SKIP = 7'h40
  } rtcp_dst_t;

  typedef enum logic [3:0] {
    M_IDLE  = 4'h1,
    M_START = 4'h2,
    M_BYTE  = 4'h4,
    M_STOP  = 4'h8
  } rtcp_mst_t;
endpackage

// ==== rtcp_if.sv ====
// Two-wire bus between the master end and the device end.
`timescale 1ns/1ps
interface rtcp_if;
  logic scl;
  logic mst_sda_o;
  logic mst_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic sda;

  // The pulled-up data wire is low when any enabled driver pulls it low.
  assign sda = (mst_sda_oe_n | mst_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport mst (
    output scl,
    output mst_sda_o,
    output mst_sda_oe_n,
    input  sda
  );

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe_n
  );
endinterface

// ==== rtcp_mst.sv ====
// Master end of the two-wire bus with its write data FIFO.
`timescale 1ns/1ps
module rtcp_fifo #(
  parameter int W = rtcp_pkg::FIFO_W,
  parameter int D = rtcp_pkg::FIFO_D
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);

  if (D < 2 || (1 << AW) != D || W < 1)
  begin : g_chk
    $error("FIFO depth must be a power of two of at least two.");
  end

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          pop;

  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign o_out_data = mem[rp_q];

  always_ff @(posedge i_clk)
  begin
    if (i_ce && push)
      mem[wp_q] <= i_in_data;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end
    else if (i_ce)
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_d;
      o_in_ready <= cnt_d != (AW+1)'(D);
      o_out_valid <= cnt_d != '0;
    end
  end
endmodule

module rtcp_mst #(
  parameter int QTR = rtcp_pkg::SCL_QTR_CYC
) (
  input  wire logic       I_CLK,
  input  wire logic       I_RST,
  input  wire logic       I_CE,
  rtcp_if.mst             BUS,
  input  wire logic       I_CMD_VALID,
  output logic            O_CMD_READY,
  input  wire logic       I_CMD_RD,
  input  wire logic       I_CMD_SETPTR,
  input  wire logic [7:0] I_CMD_PTR,
  input  wire logic [7:0] I_CMD_LEN,
  input  wire logic       I_WD_VALID,
  input  wire logic [7:0] I_WD_DATA,
  output logic            O_WD_READY,
  output logic            O_RD_VALID,
  output logic [7:0]      O_RD_DATA,
  output logic            O_NACK
);
  localparam int DW = $clog2(QTR + 1);

  if (QTR < 1)
  begin : g_chk
    $error("Quarter bit time must be at least one cycle.");
  end

  rtcp_pkg::rtcp_mst_t state_q;
  logic [DW-1:0] div_q;
  logic [1:0]    sda_s_q;
  logic [1:0]    ph_q;
  logic [3:0]    bit_q;
  logic [1:0]    kind_q;
  logic [7:0]    sh_q;
  logic [7:0]    ptr_q;
  logic [7:0]    left_q;
  logic          rd_q;
  logic          pend_q;
  logic          setp_q;
  logic          ackd_q;
  logic          scl_q;
  logic          oe_n_q;
  logic          tick;
  logic          sda;
  logic          rx;
  logic          stall;
  logic          pop;
  logic          f_vld;
  logic [7:0]    f_data;
  logic [7:0]    cur;

  rtcp_fifo #(.W(8), .D(rtcp_pkg::FIFO_D)) u_fifo (
    .i_clk       (I_CLK),
    .i_rst       (I_RST),
    .i_ce        (I_CE),
    .i_in_valid  (I_WD_VALID),
    .i_in_data   (I_WD_DATA),
    .o_in_ready  (O_WD_READY),
    .o_out_valid (f_vld),
    .o_out_data  (f_data),
    .i_out_ready (pop)
  );

  assign sda = sda_s_q[1];
  assign tick = div_q == '0;
  assign rx = kind_q == rtcp_pkg::K_RD;
  assign stall = kind_q == rtcp_pkg::K_WD && bit_q == 4'h0 && !f_vld;
  assign cur = (kind_q == rtcp_pkg::K_WD && bit_q == 4'h0) ? f_data : sh_q;
  assign pop = I_CE & tick & (state_q == rtcp_pkg::M_BYTE) & (ph_q == 2'h0)
             & (kind_q == rtcp_pkg::K_WD) & (bit_q == 4'h0) & f_vld;
  assign O_CMD_READY = state_q[0];
  assign BUS.scl = scl_q;
  assign BUS.mst_sda_o = 1'b0;
  assign BUS.mst_sda_oe_n = oe_n_q;

  // Quarter bit timer that paces every clock phase the master makes.
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      div_q <= '0;
    else if (I_CE)
      div_q <= tick ? DW'(QTR - 1) : div_q - 1'b1;
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      sda_s_q <= 2'h3;
    else if (I_CE)
      sda_s_q <= {sda_s_q[0], BUS.sda};
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      state_q <= rtcp_pkg::M_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      kind_q <= rtcp_pkg::K_ADDR;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      left_q <= 8'h00;
      rd_q <= 1'b0;
      pend_q <= 1'b0;
      setp_q <= 1'b0;
      ackd_q <= 1'b0;
      scl_q <= 1'b1;
      oe_n_q <= 1'b1;
      O_RD_VALID <= 1'b0;
      O_RD_DATA <= 8'h00;
      O_NACK <= 1'b0;
    end
    else if (I_CE)
    begin
      O_RD_VALID <= 1'b0;
      O_NACK <= 1'b0;
      case (state_q)
        rtcp_pkg::M_IDLE:
          if (I_CMD_VALID)
          begin
            rd_q <= I_CMD_RD & ~I_CMD_SETPTR;
            pend_q <= I_CMD_RD & I_CMD_SETPTR;
            setp_q <= I_CMD_SETPTR | ~I_CMD_RD;
            ptr_q <= I_CMD_PTR;
            left_q <= I_CMD_LEN;
            kind_q <= rtcp_pkg::K_ADDR;
            bit_q <= 4'h0;
            ph_q <= 2'h0;
            sh_q <= {rtcp_pkg::SLV_ADDR, I_CMD_RD & ~I_CMD_SETPTR};
            state_q <= rtcp_pkg::M_START;
          end
        rtcp_pkg::M_START:
          if (tick)
          begin
            case (ph_q)
              2'h0: if (scl_q && sda) ph_q <= 2'h1;
              2'h1:
              begin
                oe_n_q <= 1'b0;
                ph_q <= 2'h2;
              end
              2'h2:
              begin
                scl_q <= 1'b0;
                ph_q <= 2'h3;
              end
              default:
              begin
                ph_q <= 2'h0;
                state_q <= rtcp_pkg::M_BYTE;
              end
            endcase
          end
        rtcp_pkg::M_BYTE:
          if (tick)
          begin
            case (ph_q)
              2'h0:
                if (!stall)
                begin
                  // Data moves only here, at least a quarter after the clock fell.
                  if (bit_q == rtcp_pkg::ACK_SLOT)
                    oe_n_q <= rx ? (left_q == 8'h01) : 1'b1;
                  else if (rx)
                    oe_n_q <= 1'b1;
                  else
                  begin
                    oe_n_q <= cur[7];
                    sh_q <= {cur[6:0], 1'b0};
                  end
                  ph_q <= 2'h1;
                end
              2'h1:
              begin
                scl_q <= 1'b1;
                ph_q <= 2'h2;
              end
              2'h2:
              begin
                if (bit_q == rtcp_pkg::ACK_SLOT)
                  ackd_q <= ~sda;
                else if (rx)
                  sh_q <= {sh_q[6:0], sda};
                ph_q <= 2'h3;
              end
              default:
              begin
                scl_q <= 1'b0;
                ph_q <= 2'h0;
                if (bit_q != rtcp_pkg::ACK_SLOT)
                  bit_q <= bit_q + 1'b1;
                else
                begin
                  bit_q <= 4'h0;
                  case (kind_q)
                    rtcp_pkg::K_ADDR:
                      if (!ackd_q)
                      begin
                        O_NACK <= 1'b1;
                        pend_q <= 1'b0;
                        state_q <= rtcp_pkg::M_STOP;
                      end
                      else if (rd_q && left_q != 8'h00)
                        kind_q <= rtcp_pkg::K_RD;
                      else if (setp_q)
                      begin
                        kind_q <= rtcp_pkg::K_PTR;
                        sh_q <= ptr_q;
                      end
                      else
                        state_q <= rtcp_pkg::M_STOP;
                    rtcp_pkg::K_PTR:
                      if (!pend_q && left_q != 8'h00)
                        kind_q <= rtcp_pkg::K_WD;
                      else
                        state_q <= rtcp_pkg::M_STOP;
                    default:
                    begin
                      left_q <= left_q - 1'b1;
                      if (rx)
                      begin
                        O_RD_VALID <= 1'b1;
                        O_RD_DATA <= sh_q;
                      end
                      if (left_q == 8'h01)
                        state_q <= rtcp_pkg::M_STOP;
                    end
                  endcase
                end
              end
            endcase
          end
        rtcp_pkg::M_STOP:
          if (tick)
          begin
            case (ph_q)
              2'h0:
              begin
                oe_n_q <= 1'b0;
                ph_q <= 2'h1;
              end
              2'h1:
              begin
                scl_q <= 1'b1;
                ph_q <= 2'h2;
              end
              2'h2:
              begin
                oe_n_q <= 1'b1;
                ph_q <= 2'h3;
              end
              default:
              begin
                ph_q <= 2'h0;
                if (pend_q)
                begin
                  // A pointer set is always closed before the read begins.
                  pend_q <= 1'b0;
                  rd_q <= 1'b1;
                  setp_q <= 1'b0;
                  kind_q <= rtcp_pkg::K_ADDR;
                  sh_q <= {rtcp_pkg::SLV_ADDR, rtcp_pkg::RW_RD};
                  state_q <= rtcp_pkg::M_START;
                end
                else
                  state_q <= rtcp_pkg::M_IDLE;
              end
            endcase
          end
        default: state_q <= rtcp_pkg::M_IDLE;
      endcase
    end
  end
endmodule

// ==== rtcp_dev.sv ====
// Device end of the two-wire bus: paged pointer, snapshot cache and live registers.
`timescale 1ns/1ps
// How it works
// - Master ends transfer with stop before start.
// - Start and stop seen while clock high.
// - Data changes only while clock low.
// - First byte: seven address bits, then direction.
// - Answer only the write and read address.
// - Second write byte is page and word pointer.
// - Word part advances after each acknowledged byte.
// - Withheld acknowledge leaves pointer unchanged.
// - Receiver pulls data low through ninth pulse.
// - Master acknowledges reads, withholds on last.
// - After withheld acknowledge, device releases data.
// - Master makes all clocks; device drives data only.
// - Start copies live registers into the cache.
// - Cache stays frozen until the stop.
// - Stop after write copies modified entries back.
// - Random read: set pointer, stop, then read.
// - Plain read starts at last read address, or last written plus one.
// - Any byte count, each with acknowledge slot.
// - Master starts only on an idle bus.
// - Data line is only pulled low or released.
module rtcp_dev #(
  parameter int PAGE_W = rtcp_pkg::PAGE_W,
  parameter int WORD_W = rtcp_pkg::WORD_W
) (
  input  wire logic                     I_CLK,
  input  wire logic                     I_RST,
  input  wire logic                     I_CE,
  rtcp_if.dev                           BUS,
  input  wire logic                     I_UPD_WE,
  input  wire logic [PAGE_W+WORD_W-1:0] I_UPD_ADDR,
  input  wire logic [7:0]               I_UPD_DATA,
  input  wire logic [PAGE_W+WORD_W-1:0] I_LIVE_ADDR,
  output logic [7:0]                    O_LIVE_DATA,
  output logic                          O_BUSY,
  output logic                          O_WB,
  output logic [PAGE_W+WORD_W-1:0]      O_PTR
);
  localparam int PW = PAGE_W + WORD_W;
  localparam int DEPTH = 1 << PW;

  if (PAGE_W < 1 || WORD_W < 1 || PW != 8)
  begin : g_chk
    $error("Page and word widths must fill exactly one byte.");
  end

  // Next pointer: the word part counts, the page part holds.
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = {p[PW-1:WORD_W], p[WORD_W-1:0] + 1'b1};
  endfunction

  rtcp_pkg::rtcp_dst_t state_q;
  logic [2:0]    scl_s_q;
  logic [2:0]    sda_s_q;
  logic [2:0]    cnt_q;
  logic [7:0]    sh_q;
  logic [PW-1:0] ptr_q;
  logic          rw_q;
  logic          wr_q;
  logic          first_q;
  logic          full_q;
  logic          mack_q;
  logic          oe_n_q;
  logic [7:0]    cache [DEPTH];
  logic [7:0]    live [DEPTH];
  logic [DEPTH-1:0] dirty_q;
  logic          scl;
  logic          scl_p;
  logic          sda;
  logic          sda_p;
  logic          start_e;
  logic          stop_e;
  logic          rise;
  logic          fall;
  logic          cwr;
  logic          wb;
  logic [7:0]    cur;
  logic [7:0]    nxt;

  assign scl = scl_s_q[1];
  assign scl_p = scl_s_q[2];
  assign sda = sda_s_q[1];
  assign sda_p = sda_s_q[2];
  assign start_e = scl & scl_p & sda_p & ~sda;
  assign stop_e = scl & scl_p & ~sda_p & sda;
  assign rise = scl & ~scl_p;
  assign fall = ~scl & scl_p;
  assign cwr = fall & (state_q == rtcp_pkg::D_RX) & full_q & ~first_q;
  assign wb = stop_e & wr_q;
  assign cur = cache[ptr_q];
  assign nxt = cache[ptr_inc(ptr_q)];
  assign O_PTR = ptr_q;
  assign BUS.dev_sda_o = 1'b0;
  assign BUS.dev_sda_oe_n = oe_n_q;

  // Two-stage synchronisers; the third stage only remembers the last level.
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end
    else if (I_CE)
    begin
      scl_s_q <= {scl_s_q[1:0], BUS.scl};
      sda_s_q <= {sda_s_q[1:0], BUS.sda};
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      state_q <= rtcp_pkg::D_IDLE;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      ptr_q <= rtcp_pkg::PTR_RST;
      rw_q <= 1'b0;
      wr_q <= 1'b0;
      first_q <= 1'b0;
      full_q <= 1'b0;
      mack_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else if (I_CE)
    begin
      if (stop_e)
      begin
        state_q <= rtcp_pkg::D_IDLE;
        oe_n_q <= 1'b1;
        wr_q <= 1'b0;
      end
      else if (start_e)
      begin
        // A start in mid transfer drops it and begins afresh.
        state_q <= rtcp_pkg::D_ADDR;
        cnt_q <= 3'h0;
        full_q <= 1'b0;
        oe_n_q <= 1'b1;
        wr_q <= 1'b0;
        first_q <= 1'b1;
      end
      else if (rise)
      begin
        case (state_q)
          rtcp_pkg::D_ADDR, rtcp_pkg::D_RX:
          begin
            sh_q <= {sh_q[6:0], sda};
            cnt_q <= cnt_q + 1'b1;
            full_q <= cnt_q == rtcp_pkg::BIT_LAST;
          end
          rtcp_pkg::D_MACK: mack_q <= ~sda;
          default: mack_q <= mack_q;
        endcase
      end
      else if (fall)
      begin
        // Every drive change waits for the clock to be low.
        case (state_q)
          rtcp_pkg::D_ADDR:
            if (full_q)
            begin
              full_q <= 1'b0;
              if (sh_q[7:1] == rtcp_pkg::SLV_ADDR)
              begin
                rw_q <= sh_q[0];
                wr_q <= sh_q[0] == rtcp_pkg::RW_WR;
                oe_n_q <= 1'b0;
                state_q <= rtcp_pkg::D_ACK;
              end
              else
                state_q <= rtcp_pkg::D_SKIP;
            end
          rtcp_pkg::D_RX:
            if (full_q)
            begin
              full_q <= 1'b0;
              if (first_q)
                ptr_q <= sh_q;
              else
                ptr_q <= ptr_inc(ptr_q);
              first_q <= 1'b0;
              oe_n_q <= 1'b0;
              state_q <= rtcp_pkg::D_ACK;
            end
          rtcp_pkg::D_ACK:
          begin
            cnt_q <= 3'h0;
            if (rw_q == rtcp_pkg::RW_RD)
            begin
              oe_n_q <= cur[7];
              sh_q <= {cur[6:0], 1'b0};
              state_q <= rtcp_pkg::D_TX;
            end
            else
            begin
              oe_n_q <= 1'b1;
              state_q <= rtcp_pkg::D_RX;
            end
          end
          rtcp_pkg::D_TX:
            if (cnt_q == rtcp_pkg::BIT_LAST)
            begin
              cnt_q <= 3'h0;
              oe_n_q <= 1'b1;
              state_q <= rtcp_pkg::D_MACK;
            end
            else
            begin
              cnt_q <= cnt_q + 1'b1;
              oe_n_q <= sh_q[7];
              sh_q <= {sh_q[6:0], 1'b0};
            end
          rtcp_pkg::D_MACK:
            if (mack_q)
            begin
              ptr_q <= ptr_inc(ptr_q);
              oe_n_q <= nxt[7];
              sh_q <= {nxt[6:0], 1'b0};
              state_q <= rtcp_pkg::D_TX;
            end
            else
            begin
              oe_n_q <= 1'b1;
              state_q <= rtcp_pkg::D_SKIP;
            end
          default: oe_n_q <= 1'b1;
        endcase
      end
    end
  end

  // The cache is loaded only at start and changed only by received data.
  always_ff @(posedge I_CLK)
  begin
    if (I_CE)
    begin
      if (start_e)
      begin
        for (int i = 0; i < DEPTH; i++)
          cache[i] <= live[i];
      end
      else if (cwr)
        cache[ptr_q] <= sh_q;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      dirty_q <= '0;
    else if (I_CE)
    begin
      if (start_e)
        dirty_q <= '0;
      else if (cwr)
        dirty_q[ptr_q] <= 1'b1;
    end
  end

  // Write-back of modified entries takes priority over an internal update.
  always_ff @(posedge I_CLK)
  begin
    if (I_CE)
    begin
      if (I_UPD_WE)
        live[I_UPD_ADDR] <= I_UPD_DATA;
      if (wb)
      begin
        for (int i = 0; i < DEPTH; i++)
          if (dirty_q[i])
            live[i] <= cache[i];
      end
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_LIVE_DATA <= 8'h00;
      O_BUSY <= 1'b0;
      O_WB <= 1'b0;
    end
    else if (I_CE)
    begin
      O_LIVE_DATA <= live[I_LIVE_ADDR];
      O_BUSY <= ~stop_e & (start_e | O_BUSY);
      O_WB <= wb;
    end
  end
endmodule

// ==== rtcp_properties.sv ====
// Concurrent checks on the two-wire bus between both ends.
`timescale 1ns/1ps
module rtcp_properties #(
  parameter int QTR = rtcp_pkg::SCL_QTR_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic scl,
  input wire logic mst_sda_o,
  input wire logic mst_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic sda
);
  logic [7:0] hi_q;
  logic [7:0] idle_q;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  // Counts clock high cycles.
  always_ff @(posedge I_CLK)
  begin
    if (I_RST || !scl)
      hi_q <= 8'h00;
    else if (hi_q != 8'hFF)
      hi_q <= hi_q + 8'h01;
  end

  // Counts idle bus cycles.
  always_ff @(posedge I_CLK)
  begin
    if (I_RST || !(scl && sda))
      idle_q <= 8'h00;
    else if (idle_q != 8'hFF)
      idle_q <= idle_q + 8'h01;
  end

  scl_high_len_a: assert property ($fell(scl) |-> hi_q >= 8'(2 * QTR))
    else $error("clock high phase too short");
  start_idle_a: assert property ($fell(sda) && scl && $past(scl) |-> idle_q >= 8'(QTR))
    else $error("start on a busy bus");
  stop_release_a: assert property ($rose(sda) && scl |-> dev_sda_oe_n [*3])
    else $error("device drives data after stop");
  dev_change_low_a: assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl))
    else $error("device data changed while clock high");
  ack_hold_a: assert property ($rose(scl) && !dev_sda_oe_n |-> (!dev_sda_oe_n) [*4])
    else $error("device low level not held through clock high");
  dev_drive_a: assert property (dev_sda_o == 1'b0)
    else $error("device drives data high");
  mst_drive_a: assert property (mst_sda_o == 1'b0)
    else $error("master drives data high");
  reset_idle_a: assert property ($past(I_RST) |-> scl && mst_sda_oe_n && dev_sda_oe_n)
    else $error("bus not idle after reset");
endmodule

// ==== testbench.sv ====
// Self-checking bench joining the master end and the device end.
`timescale 1ns/1ps
module testbench;
  logic       clk, rst, cv, crd, csp, wv, uwe;
  logic [7:0] cptr, clen, wd, ua, ud, la, pg, v;
  logic       crdy, wrdy, rdv, nack, busy, wb;
  logic [7:0] rdd, ld, ptr;
  logic [7:0] mem [256];
  logic [7:0] dq [12];
  logic [7:0] expq [$];
  int         mismatches, comparisons, wbn, nkn, n;

  rtcp_if i_rtcp_if ();
  rtcp_mst #(.QTR(2)) i_rtcp_mst (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .BUS(i_rtcp_if),
    .I_CMD_VALID(cv), .O_CMD_READY(crdy), .I_CMD_RD(crd), .I_CMD_SETPTR(csp),
    .I_CMD_PTR(cptr), .I_CMD_LEN(clen), .I_WD_VALID(wv), .I_WD_DATA(wd),
    .O_WD_READY(wrdy), .O_RD_VALID(rdv), .O_RD_DATA(rdd), .O_NACK(nack));
  rtcp_dev i_rtcp_dev (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .BUS(i_rtcp_if),
    .I_UPD_WE(uwe), .I_UPD_ADDR(ua), .I_UPD_DATA(ud), .I_LIVE_ADDR(la),
    .O_LIVE_DATA(ld), .O_BUSY(busy), .O_WB(wb), .O_PTR(ptr));
  rtcp_properties #(.QTR(2)) i_rtcp_properties (.I_CLK(clk), .I_RST(rst),
    .scl(i_rtcp_if.scl), .mst_sda_o(i_rtcp_if.mst_sda_o),
    .mst_sda_oe_n(i_rtcp_if.mst_sda_oe_n), .dev_sda_o(i_rtcp_if.dev_sda_o),
    .dev_sda_oe_n(i_rtcp_if.dev_sda_oe_n), .sda(i_rtcp_if.sda));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmd(input logic r, input logic s, input logic [7:0] p, input logic [7:0] l);
    int k;
    k = 0;
    cv <= 1'b1;
    crd <= r;
    csp <= s;
    cptr <= p;
    clen <= l;
    tick(1);
    cv <= 1'b0;
    do
      tick(1);
    while (crdy !== 1'b1 && ++k < 20000);
    if (k >= 20000)
      chk("command done", 8'h01, 8'h00);
  endtask

  task automatic look(input logic [7:0] a);
    la <= a;
    tick(2);
    chk("live data", mem[a], ld);
  endtask

  // Compares each read byte with the oldest expected one.
  always @(posedge clk)
  begin
    if (wb === 1'b1)
      wbn++;
    if (nack === 1'b1)
      nkn++;
    if (rdv === 1'b1)
      chk("read byte", (expq.size() > 0) ? expq.pop_front() : ~rdd, rdd);
  end

  initial
  begin
    #400000;
    mismatches++;
    results();
  end

  initial
  begin
    {cv, crd, csp, wv, uwe} = 5'h00;
    {cptr, clen, wd, ua, ud, la} = 48'h0;
    rst = 1'b1;
    void'($urandom(30));
    tick(12);
    rst <= 1'b0;
    for (n = 0; n < 256; n++)
    begin
      v = 8'($urandom);
      mem[n] = v;
      uwe <= 1'b1;
      ua <= 8'(n);
      ud <= v;
      tick(1);
    end
    uwe <= 1'b0;
    pg = 8'($urandom) & 8'hF8;
    wv <= 1'b1;
    for (n = 0; n < 12; n++)
    begin
      dq[n] = 8'($urandom);
      wd <= dq[n];
      tick(1);
      if (wrdy !== 1'b1)
        break;
    end
    wv <= 1'b0;
    chk("fifo depth", 8'(rtcp_pkg::FIFO_D), 8'(n));
    for (n = 0; n < 8; n++)
      mem[pg | 8'((6 + n) % 8)] = dq[n];
    cmd(1'b0, 1'b1, pg | 8'h06, 8'h08);
    chk("pointer wrap", pg | 8'h06, ptr);
    v = 8'($urandom);
    mem[pg | 8'h02] = v;
    fork
      cmd(1'b0, 1'b1, pg | 8'h02, 8'h01);
      begin
        tick(300);
        wv <= 1'b1;
        wd <= v;
        tick(1);
        wv <= 1'b0;
      end
    join
    chk("pointer step", pg | 8'h03, ptr);
    for (n = 0; n < 8; n++)
      look(pg | 8'(n));
    expq.push_back(mem[pg | 8'h07]);
    expq.push_back(mem[pg]);
    expq.push_back(mem[pg | 8'h01]);
    cmd(1'b1, 1'b1, pg | 8'h07, 8'h03);
    chk("pointer kept", pg | 8'h01, ptr);
    expq.push_back(mem[pg | 8'h01]);
    expq.push_back(mem[pg | 8'h02]);
    fork
      cmd(1'b1, 1'b0, 8'h00, 8'h02);
      begin
        n = 0;
        tick(1);
        while (busy !== 1'b1 && n < 5000)
        begin
          tick(1);
          n++;
        end
        uwe <= 1'b1;
        ua <= pg | 8'h02;
        ud <= ~mem[pg | 8'h02];
        tick(1);
        uwe <= 1'b0;
      end
    join
    mem[pg | 8'h02] = ~mem[pg | 8'h02];
    look(pg | 8'h02);
    chk("pending reads", 8'h00, 8'(expq.size()));
    chk("write backs", 8'h03, 8'(wbn));
    chk("address refusals", 8'h00, 8'(nkn));
    results();
  end
endmodule
